// file: verilog/strap_config_capture.sv
/*
  strap_config_capture: holds the captured strap configuration, exposes it
  over an AXI4-Lite slave, keeps the software-writable bits, decodes the
  wake-up port scheme and drives the start-up configuration outputs.
  assumes: one clock sys_clk, async active-low rst_n, io write strobes
  synchronous to sys_clk, at most one write and one read in flight.
*/
`timescale 1ns/10ps
`default_nettype none
module strap_config_capture (
	input  wire logic        sys_clk,
	input  wire logic        rst_n,
	input  wire logic [15:0] first_memory_data_bus,   // strap sample, bus one
	input  wire logic [15:0] second_memory_data_bus,  // strap sample, bus two
	output logic             memory_data_pullup_en,   // weak pullups on
	input  wire logic        io_wr_stb,               // host io write
	input  wire logic [15:0] io_addr,
	input  wire logic [7:0]  io_wdata,
	output logic             subsystem_awake,
	output logic             rom_mapped_out,
	output logic             aux_video_clock_one_oe,
	output logic             aux_video_clock_two_oe,
	output logic [1:0]       bus_arch_sel,            // {strap 17, strap 2}
	output logic [2:0]       memory_mode_sel,         // {16, 14, 13}
	output logic             wake_port_alt,
	output logic             voltage_force_stored,
	output logic             host_is_32bit,
	output logic             local_bus_clk_1x,
	output logic [1:0]       panel_select,
	output logic [5:0]       local_bus_interface_2df1_preset,
	output logic [3:0]       local_bus_interface_2df0_preset,
	output logic             config_valid,
	input  wire logic [7:0]  s_axi_awaddr,
	input  wire logic        s_axi_awvalid,
	output logic             s_axi_awready,
	input  wire logic [31:0] s_axi_wdata,
	input  wire logic [3:0]  s_axi_wstrb,
	input  wire logic        s_axi_wvalid,
	output logic             s_axi_wready,
	output logic [1:0]       s_axi_bresp,
	output logic             s_axi_bvalid,
	input  wire logic        s_axi_bready,
	input  wire logic [7:0]  s_axi_araddr,
	input  wire logic        s_axi_arvalid,
	output logic             s_axi_arready,
	output logic [31:0]      s_axi_rdata,
	output logic [1:0]       s_axi_rresp,
	output logic             s_axi_rvalid,
	input  wire logic        s_axi_rready
);
	// byte offset to register select; shared by read and write paths
	function automatic scc_pkg::scc_reg_t scc_decode(input logic [7:0] a);
		if (a == scc_pkg::OFF_ROM) begin
			return scc_pkg::SCC_REG_ROM;
		end else if (a == scc_pkg::OFF_GSTAT) begin
			return scc_pkg::SCC_REG_GSTAT;
		end else if (a == scc_pkg::OFF_STRAP) begin
			return scc_pkg::SCC_REG_STRAP;
		end else if (a == scc_pkg::OFF_PANEL) begin
			return scc_pkg::SCC_REG_PANEL;
		end else if (a == scc_pkg::OFF_MEM) begin
			return scc_pkg::SCC_REG_MEM;
		end else if (a == scc_pkg::OFF_STATUS) begin
			return scc_pkg::SCC_REG_STATUS;
		end else if (a == scc_pkg::OFF_LBI) begin
			return scc_pkg::SCC_REG_LBI;
		end else begin
			return scc_pkg::SCC_REG_NONE;
		end
	endfunction

	logic [31:0]       strap_word;      // frozen capture
	logic              capture_stb;     // one pulse after reset release
	logic [31:0]       cfg_r;           // live strap word, soft bits writable
	logic [1:0]        panel_r;         // panel select register
	logic              valid_r;         // configuration ready
	logic              awake_r;         // display subsystem awake
	logic              setup_r;         // alternate scheme armed
	logic              aw_got_r;        // write address held
	logic              w_got_r;         // write data held
	logic [7:0]        aw_addr_r;
	logic [31:0]       w_data_r;
	logic [3:0]        w_strb_r;
	logic              wr_go;           // perform held write this edge
	logic [31:0]       bmask;           // byte lanes of the held write
	logic [31:0]       rd_mux;          // read data for araddr
	logic              rd_hit;          // araddr is mapped
	scc_pkg::scc_reg_t wsel;            // decoded write register
	scc_pkg::scc_reg_t rsel;            // decoded read register

	scc_strap_capture u_capture (
		.sys_clk                (sys_clk),
		.rst_n                  (rst_n),
		.first_memory_data_bus  (first_memory_data_bus),
		.second_memory_data_bus (second_memory_data_bus),
		.strap_word_r           (strap_word),
		.capture_stb_r          (capture_stb)
	);

	assign wsel  = scc_decode(aw_addr_r);
	assign rsel  = scc_decode(s_axi_araddr);
	assign wr_go = aw_got_r && w_got_r && !s_axi_bvalid;
	assign bmask = {{8{w_strb_r[3]}}, {8{w_strb_r[2]}}, {8{w_strb_r[1]}}, {8{w_strb_r[0]}}};

	// read mux; rom and general status bits read 1 where a pulldown was fitted
	always_comb begin
		rd_mux = '0;
		rd_hit = 1'b1;
		case (rsel)
			scc_pkg::SCC_REG_ROM: begin
				rd_mux[scc_pkg::SB_ROM]  = ~cfg_r[scc_pkg::SB_ROM];
				rd_mux[scc_pkg::SB_RSV1] = ~cfg_r[scc_pkg::SB_RSV1];
			end
			scc_pkg::SCC_REG_GSTAT: begin
				rd_mux[scc_pkg::SB_GP_LO +: scc_pkg::GP_W] =
					~cfg_r[scc_pkg::SB_GP_LO +: scc_pkg::GP_W];
			end
			scc_pkg::SCC_REG_STRAP: rd_mux = cfg_r;
			scc_pkg::SCC_REG_PANEL: rd_mux[1:0] = panel_r;
			scc_pkg::SCC_REG_MEM: begin
				rd_mux[scc_pkg::MEM_ARCH_BIT] = cfg_r[scc_pkg::SB_ARCH_HI];
				rd_mux[scc_pkg::MEM_LO_BIT]   = cfg_r[scc_pkg::SB_MEM_LO];
				rd_mux[scc_pkg::MEM_MID_BIT]  = cfg_r[scc_pkg::SB_MEM_MID];
				rd_mux[scc_pkg::MEM_HI_BIT]   = cfg_r[scc_pkg::SB_MEM_HI];
			end
			scc_pkg::SCC_REG_STATUS: begin
				rd_mux[scc_pkg::ST_VALID] = valid_r;
				rd_mux[scc_pkg::ST_AWAKE] = awake_r;
				rd_mux[scc_pkg::ST_SETUP] = setup_r;
			end
			scc_pkg::SCC_REG_LBI: begin
				rd_mux[scc_pkg::LBI1_W-1:0] = cfg_r[scc_pkg::SB_2DF1 +: scc_pkg::LBI1_W];
				rd_mux[scc_pkg::LBI0_LSB +: scc_pkg::LBI0_W] =
					cfg_r[scc_pkg::SB_2DF0 +: scc_pkg::LBI0_W];
			end
			default: rd_hit = 1'b0;
		endcase
	end

	// configuration store: loaded whole at capture, afterwards only the
	// soft bits and panel_r move; capture wins because the bus is not ready before it
	always_ff @(posedge sys_clk or negedge rst_n) begin
		if (!rst_n) begin
			cfg_r   <= '0;
			panel_r <= '0;
			valid_r <= 1'b0;
		end else if (capture_stb) begin
			cfg_r   <= strap_word;
			panel_r <= strap_word[scc_pkg::SB_PANEL +: 2];
			valid_r <= 1'b1;
		end else if (wr_go) begin
			case (wsel)
				scc_pkg::SCC_REG_ROM: begin
					if (w_strb_r[0]) begin
						cfg_r[scc_pkg::SB_ROM] <= ~w_data_r[scc_pkg::SB_ROM];
					end
				end
				scc_pkg::SCC_REG_STRAP: begin
					cfg_r <= (cfg_r & ~(scc_pkg::SOFT_MASK & bmask)) |
						(w_data_r & scc_pkg::SOFT_MASK & bmask);
				end
				scc_pkg::SCC_REG_PANEL: begin
					if (w_strb_r[0]) begin
						panel_r <= w_data_r[1:0];
					end
				end
				scc_pkg::SCC_REG_MEM: begin
					if (w_strb_r[0]) begin
						cfg_r[scc_pkg::SB_MEM_LO]  <= w_data_r[scc_pkg::MEM_LO_BIT];
						cfg_r[scc_pkg::SB_MEM_MID] <= w_data_r[scc_pkg::MEM_MID_BIT];
					end
				end
				default: begin
					cfg_r <= cfg_r;
				end
			endcase
		end
	end

	// write channels: address and data taken in either order, one write
	// in flight; ready stays low until the straps are captured
	always_ff @(posedge sys_clk or negedge rst_n) begin
		if (!rst_n) begin
			s_axi_awready <= 1'b0;
			s_axi_wready  <= 1'b0;
			s_axi_bvalid  <= 1'b0;
			s_axi_bresp   <= scc_pkg::RESP_OKAY;
			aw_got_r      <= 1'b0;
			w_got_r       <= 1'b0;
			aw_addr_r     <= '0;
			w_data_r      <= '0;
			w_strb_r      <= '0;
		end else begin
			if (capture_stb) begin
				s_axi_awready <= 1'b1;
				s_axi_wready  <= 1'b1;
			end
			if (s_axi_awvalid && s_axi_awready) begin
				aw_addr_r     <= s_axi_awaddr;
				aw_got_r      <= 1'b1;
				s_axi_awready <= 1'b0;
			end
			if (s_axi_wvalid && s_axi_wready) begin
				w_data_r     <= s_axi_wdata;
				w_strb_r     <= s_axi_wstrb;
				w_got_r      <= 1'b1;
				s_axi_wready <= 1'b0;
			end
			if (wr_go) begin
				aw_got_r     <= 1'b0;
				w_got_r      <= 1'b0;
				s_axi_bvalid <= 1'b1;
				// read-only registers accept and ignore, unmapped is refused
				s_axi_bresp  <= (wsel == scc_pkg::SCC_REG_NONE) ?
					scc_pkg::RESP_SLVERR : scc_pkg::RESP_OKAY;
			end
			if (s_axi_bvalid && s_axi_bready) begin
				s_axi_bvalid  <= 1'b0;
				s_axi_awready <= 1'b1;
				s_axi_wready  <= 1'b1;
			end
		end
	end

	// read channel: answer on the same edge that takes the address
	always_ff @(posedge sys_clk or negedge rst_n) begin
		if (!rst_n) begin
			s_axi_arready <= 1'b0;
			s_axi_rvalid  <= 1'b0;
			s_axi_rdata   <= '0;
			s_axi_rresp   <= scc_pkg::RESP_OKAY;
		end else begin
			if (capture_stb) begin
				s_axi_arready <= 1'b1;
			end
			if (s_axi_arvalid && s_axi_arready) begin
				s_axi_arready <= 1'b0;
				s_axi_rvalid  <= 1'b1;
				s_axi_rdata   <= rd_mux;
				s_axi_rresp   <= rd_hit ? scc_pkg::RESP_OKAY : scc_pkg::RESP_SLVERR;
			end else if (s_axi_rvalid && s_axi_rready) begin
				s_axi_rvalid  <= 1'b0;
				s_axi_arready <= 1'b1;
			end
		end
	end

	// wake-up decode; the scheme is fixed by strap bit 9
	always_ff @(posedge sys_clk or negedge rst_n) begin
		if (!rst_n) begin
			awake_r <= 1'b0;
			setup_r <= 1'b0;
		end else if (valid_r && io_wr_stb) begin
			if (!cfg_r[scc_pkg::SB_WAKE]) begin
				if (io_addr == scc_pkg::PORT_WAKE) begin
					awake_r <= io_wdata[scc_pkg::WAKE_BIT];
				end
			end else if (io_addr == scc_pkg::PORT_SETUP) begin
				setup_r <= io_wdata[scc_pkg::SETUP_BIT];
			end else if (setup_r && io_addr[11:0] == scc_pkg::PORT_ENA) begin
				awake_r <= io_wdata[scc_pkg::WAKE_BIT];
			end
		end
	end

	// output stage: every configuration output straight from a flop
	always_ff @(posedge sys_clk or negedge rst_n) begin
		if (!rst_n) begin
			memory_data_pullup_en           <= 1'b1;
			subsystem_awake                 <= 1'b0;
			rom_mapped_out                  <= 1'b0;
			aux_video_clock_one_oe          <= 1'b0;
			aux_video_clock_two_oe          <= 1'b0;
			bus_arch_sel                    <= '0;
			memory_mode_sel                 <= '0;
			wake_port_alt                   <= 1'b0;
			voltage_force_stored            <= 1'b1;
			host_is_32bit                   <= 1'b0;
			local_bus_clk_1x                <= 1'b0;
			panel_select                    <= '0;
			local_bus_interface_2df1_preset <= '0;
			local_bus_interface_2df0_preset <= '0;
			config_valid                    <= 1'b0;
		end else begin
			memory_data_pullup_en           <= 1'b1;
			subsystem_awake                 <= awake_r;
			rom_mapped_out                  <= ~cfg_r[scc_pkg::SB_ROM];
			aux_video_clock_one_oe          <= cfg_r[scc_pkg::SB_VCLK];
			aux_video_clock_two_oe          <= cfg_r[scc_pkg::SB_VCLK];
			bus_arch_sel                    <= {cfg_r[scc_pkg::SB_ARCH_HI],
				cfg_r[scc_pkg::SB_ARCH_LO]};
			memory_mode_sel                 <= {cfg_r[scc_pkg::SB_MEM_HI],
				cfg_r[scc_pkg::SB_MEM_MID], cfg_r[scc_pkg::SB_MEM_LO]};
			wake_port_alt                   <= cfg_r[scc_pkg::SB_WAKE];
			voltage_force_stored            <= ~cfg_r[scc_pkg::SB_SWAP_B];
			host_is_32bit                   <= cfg_r[scc_pkg::SB_HOST];
			local_bus_clk_1x                <= cfg_r[scc_pkg::SB_LBCLK];
			panel_select                    <= panel_r;
			local_bus_interface_2df1_preset <= cfg_r[scc_pkg::SB_2DF1 +: scc_pkg::LBI1_W];
			local_bus_interface_2df0_preset <= cfg_r[scc_pkg::SB_2DF0 +: scc_pkg::LBI0_W];
			config_valid                    <= valid_r;
		end
	end

	fixed_bits_a: assert property (@(posedge sys_clk) disable iff (!rst_n)
		valid_r && !capture_stb ##1 1'b1 |->
			(cfg_r & ~scc_pkg::SOFT_MASK) == $past(cfg_r & ~scc_pkg::SOFT_MASK))
		else $error("fixed strap bit changed after capture");
	rom_map_a: assert property (@(posedge sys_clk) disable iff (!rst_n)
		valid_r |=> rom_mapped_out == ~$past(cfg_r[scc_pkg::SB_ROM]))
		else $error("rom map output disagrees with strap bit 0");
	vclk_dir_a: assert property (@(posedge sys_clk) disable iff (!rst_n)
		capture_stb |=> ##1 aux_video_clock_one_oe == $past(strap_word[scc_pkg::SB_VCLK], 2)
			&& aux_video_clock_two_oe == aux_video_clock_one_oe)
		else $error("aux video clock direction wrong");
	wake_port_a: assert property (@(posedge sys_clk) disable iff (!rst_n)
		valid_r && io_wr_stb && !cfg_r[scc_pkg::SB_WAKE] && io_addr == scc_pkg::PORT_WAKE
			&& io_wdata[scc_pkg::WAKE_BIT] |=> ##1 subsystem_awake)
		else $error("single-port wake did not wake");
	volt_force_a: assert property (@(posedge sys_clk) disable iff (!rst_n)
		config_valid |-> voltage_force_stored == ~$past(cfg_r[scc_pkg::SB_SWAP_B]))
		else $error("voltage force output wrong");
	lb_clock_a: assert property (@(posedge sys_clk) disable iff (!rst_n)
		config_valid |-> local_bus_clk_1x == $past(cfg_r[scc_pkg::SB_LBCLK])
			&& host_is_32bit == $past(cfg_r[scc_pkg::SB_HOST]))
		else $error("clock rate or host width output wrong");
	panel_preset_a: assert property (@(posedge sys_clk) disable iff (!rst_n)
		capture_stb |=> panel_r == $past(strap_word[scc_pkg::SB_PANEL +: 2]))
		else $error("panel select not preset from straps");
	pullup_on_a: assert property (@(posedge sys_clk) disable iff (!rst_n)
		memory_data_pullup_en)
		else $error("memory data pullups released");
endmodule // strap_config_capture
`default_nettype wire

// file: verilog/scc_pkg.sv
/*
  scc_pkg: shared constants for the strap configuration capture block:
  strap bit positions, register offsets and fields, port numbers, enums.
  assumes: used by scc_strap_capture and strap_config_capture, always as
  scc_pkg::name, never imported.
*/
`default_nettype none
package scc_pkg;
	// widths
	localparam int BUS_W   = 16;                  // each memory data bus
	localparam int STRAP_W = 32;                  // whole strap word
	localparam int ADDR_W  = 8;                   // register bus address
	// strap bit positions
	localparam int SB_ROM     = 0;                // rom mapping
	localparam int SB_RSV1    = 1;                // reserved, readable
	localparam int SB_ARCH_LO = 2;                // bus architecture, low
	localparam int SB_VCLK    = 3;                // aux video clock direction
	localparam int SB_GP_LO   = 4;                // general status, lowest
	localparam int SB_SWAP_A  = 8;                // swapped with line 11
	localparam int SB_WAKE    = 9;                // wake-up port scheme
	localparam int SB_SWAP_B  = 11;               // voltage select
	localparam int SB_MEM_LO  = 13;               // memory mode, low
	localparam int SB_MEM_MID = 14;               // memory mode, middle
	localparam int SB_HOST    = 15;               // host width
	localparam int SB_MEM_HI  = 16;               // memory mode, high
	localparam int SB_ARCH_HI = 17;               // bus architecture, high
	localparam int SB_PANEL   = 18;               // panel select, two bits
	localparam int SB_LBCLK   = 20;               // local bus clock rate
	localparam int SB_2DF1    = 22;               // six preset bits
	localparam int SB_2DF0    = 28;               // four preset bits
	localparam int GP_W       = 3;                // general status width
	localparam int LBI1_W     = 6;                // 2DF1 preset width
	localparam int LBI0_W     = 4;                // 2DF0 preset width
	// bits software may rewrite after start-up: 15..12, 10, 0
	localparam logic [31:0] SOFT_MASK = 32'h0000_F401;
	// register byte offsets
	localparam logic [7:0] OFF_ROM    = 8'h00;    // rom_map_control_reg
	localparam logic [7:0] OFF_GSTAT  = 8'h04;    // general_status_reg
	localparam logic [7:0] OFF_STRAP  = 8'h08;    // live strap word
	localparam logic [7:0] OFF_PANEL  = 8'h0C;    // panel_select_reg
	localparam logic [7:0] OFF_MEM    = 8'h10;    // memory/bus config view
	localparam logic [7:0] OFF_STATUS = 8'h14;    // block status
	localparam logic [7:0] OFF_LBI    = 8'h18;    // local bus presets
	// register fields
	localparam int MEM_ARCH_BIT = 4;              // strap 17 image
	localparam int MEM_LO_BIT   = 5;              // strap 13, writable
	localparam int MEM_MID_BIT  = 6;              // strap 14, writable
	localparam int MEM_HI_BIT   = 7;              // strap 16 image
	localparam int ST_VALID     = 0;              // capture done
	localparam int ST_AWAKE     = 1;              // subsystem awake
	localparam int ST_SETUP     = 2;              // alternate wake armed
	localparam int LBI0_LSB     = 12;             // 2DF0[7:4] at [15:12]
	// responses
	localparam logic [1:0] RESP_OKAY   = 2'b00;
	localparam logic [1:0] RESP_SLVERR = 2'b10;
	// wake-up ports
	localparam logic [15:0] PORT_WAKE  = 16'h03C3;  // single-port scheme
	localparam logic [15:0] PORT_SETUP = 16'h46E8;  // alternate, setup port
	localparam logic [11:0] PORT_ENA   = 12'h102;   // alternate, any x102h
	localparam int WAKE_BIT  = 0;
	localparam int SETUP_BIT = 3;
	// capture sequencer
	typedef enum logic {
		SCC_CAP_SAMPLE = 1'b0,
		SCC_CAP_FROZEN = 1'b1
	} scc_cap_state_t;
	// decoded register select
	typedef enum logic [2:0] {
		SCC_REG_ROM    = 3'b000,
		SCC_REG_GSTAT  = 3'b001,
		SCC_REG_STRAP  = 3'b010,
		SCC_REG_PANEL  = 3'b011,
		SCC_REG_MEM    = 3'b100,
		SCC_REG_STATUS = 3'b101,
		SCC_REG_LBI    = 3'b110,
		SCC_REG_NONE   = 3'b111
	} scc_reg_t;
endpackage
`default_nettype wire

// file: verilog/scc_strap_capture.sv
/*
  scc_strap_capture: samples both memory data buses once, at the first
  clock edge after reset release, into the 32-bit strap word and freezes it.
  assumes: the buses are synchronous to sys_clk and carry only strap
  levels around reset release.
*/
`timescale 1ns/10ps
`default_nettype none
module scc_strap_capture (
	input  wire logic              sys_clk,
	input  wire logic              rst_n,
	input  wire logic [15:0]       first_memory_data_bus,
	input  wire logic [15:0]       second_memory_data_bus,
	output logic      [31:0]       strap_word_r,
	output logic                   capture_stb_r
);
	// line of the first bus that feeds strap bit n
	function automatic int scc_src_line(input int n);
		if (n == scc_pkg::SB_SWAP_A) begin
			return scc_pkg::SB_SWAP_B;
		end else if (n == scc_pkg::SB_SWAP_B) begin
			return scc_pkg::SB_SWAP_A;
		end else begin
			return n;
		end
	endfunction

	scc_pkg::scc_cap_state_t state_r;          // sampling or frozen
	logic [31:0]             mapped;           // bus lines in strap order

	// bits 8 and 11 cross over, the second bus fills the upper half
	genvar gi;
	generate
		for (gi = 0; gi < scc_pkg::BUS_W; gi = gi + 1) begin : g_map
			assign mapped[gi] = first_memory_data_bus[scc_src_line(gi)];
			assign mapped[gi + scc_pkg::BUS_W] = second_memory_data_bus[gi];
		end
	endgenerate

	// async reset loads only constants; the straps are taken by the
	// first clocked edge after release, then never again
	always_ff @(posedge sys_clk or negedge rst_n) begin
		if (!rst_n) begin
			state_r       <= scc_pkg::SCC_CAP_SAMPLE;
			strap_word_r  <= '0;
			capture_stb_r <= 1'b0;
		end else begin
			capture_stb_r <= 1'b0;
			case (state_r)
				scc_pkg::SCC_CAP_SAMPLE: begin
					strap_word_r  <= mapped;
					capture_stb_r <= 1'b1;
					state_r       <= scc_pkg::SCC_CAP_FROZEN;
				end
				default: begin
					state_r <= scc_pkg::SCC_CAP_FROZEN;
				end
			endcase
		end
	end

	capture_map_a: assert property (@(posedge sys_clk) disable iff (!rst_n)
		capture_stb_r |-> strap_word_r[scc_pkg::SB_SWAP_A]
			== $past(first_memory_data_bus[scc_pkg::SB_SWAP_B])
			&& strap_word_r[scc_pkg::SB_SWAP_B]
			== $past(first_memory_data_bus[scc_pkg::SB_SWAP_A]))
		else $error("swapped strap lines captured wrongly");
	capture_word_a: assert property (@(posedge sys_clk) disable iff (!rst_n)
		capture_stb_r |-> strap_word_r[31:16] == $past(second_memory_data_bus))
		else $error("upper strap half not taken from second bus");
	frozen_word_a: assert property (@(posedge sys_clk) disable iff (!rst_n)
		(state_r == scc_pkg::SCC_CAP_FROZEN) ##1 1'b1 |-> $stable(strap_word_r) && !capture_stb_r)
		else $error("strap word changed after freeze");
endmodule // scc_strap_capture
`default_nettype wire

// file: verif/scc_board_straps.sv
/*
  scc_board_straps: board strap resistors on both memory data buses.
  assumes: the mask is set while reset is low; traffic only after capture.
*/
`timescale 1ns/10ps
`default_nettype none
module scc_board_straps (
	input  wire logic [31:0] pulldown_mask,          // 1 = pulldown fitted
	input  wire logic        traffic_en,             // memory traffic after capture
	input  wire logic [31:0] traffic_data,           // value that traffic puts on the lines
	output logic      [15:0] first_memory_data_bus,
	output logic      [15:0] second_memory_data_bus
);
	// no memory drives the lines in reset, so a line without pulldown sits at the pullup
	always_comb begin
		{second_memory_data_bus, first_memory_data_bus} =
			traffic_en ? traffic_data : ~pulldown_mask;
	end
endmodule // scc_board_straps
`default_nettype wire

// file: verif/tb_top.sv
/*
  tb_top: random and corner strap patterns, capture, freeze, soft bits, registers, wake.
  assumes: straps stable across reset release; every bus answer is waited for.
*/
`timescale 1ns/10ps
`default_nettype none
module tb_top;
	logic        sys_clk = '0, rst_n = '0, te = '0, io_wr_stb = '0, ha, hw, da, dw;
	logic        s_axi_awvalid = '0, s_axi_wvalid = '0, s_axi_bready = '0;
	logic        s_axi_arvalid = '0, s_axi_rready = '0, o1, o2, s_axi_awready, s_axi_wready;
	logic        s_axi_bvalid, s_axi_arready, s_axi_rvalid, memory_data_pullup_en;
	logic        subsystem_awake, rom_mapped_out, wake_port_alt, voltage_force_stored;
	logic        host_is_32bit, local_bus_clk_1x, config_valid;
	logic [7:0]  s_axi_awaddr = '0, s_axi_araddr = '0, io_wdata = '0;
	logic [15:0] io_addr = '0, first_memory_data_bus, second_memory_data_bus;
	logic [31:0] pm = '0, td = '0, s_axi_wdata = '0, s_axi_rdata, w, d;
	logic [3:0]  s_axi_wstrb = 4'hF, p0;
	logic [1:0]  r, s_axi_bresp, s_axi_rresp, panel_select, bus_arch_sel;
	logic [2:0]  memory_mode_sel;
	logic [5:0]  p1;
	int          fail_count = 0, comparisons = 0, guard = 0;
	always #5 sys_clk = ~sys_clk;
	scc_board_straps u_board (.pulldown_mask(pm), .traffic_en(te), .traffic_data(td),
		.first_memory_data_bus, .second_memory_data_bus);
	strap_config_capture dut (.sys_clk, .rst_n, .first_memory_data_bus,
		.second_memory_data_bus, .memory_data_pullup_en, .io_wr_stb, .io_addr, .io_wdata,
		.subsystem_awake, .rom_mapped_out, .aux_video_clock_one_oe(o1),
		.aux_video_clock_two_oe(o2), .bus_arch_sel, .memory_mode_sel, .wake_port_alt,
		.voltage_force_stored, .host_is_32bit, .local_bus_clk_1x, .panel_select,
		.local_bus_interface_2df1_preset(p1), .local_bus_interface_2df0_preset(p0),
		.config_valid, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata,
		.s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid,
		.s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata,
		.s_axi_rresp, .s_axi_rvalid, .s_axi_rready);
	// strap word from a pulldown mask: line level, lines 8 and 11 trade places
	function automatic logic [31:0] exp_word(input logic [31:0] m);
		logic [31:0] l;
		l = ~m;
		return {l[31:12], l[8], l[10:9], l[11], l[7:0]};
	endfunction
	task results;
		if (fail_count == 0 && comparisons > 0)
			$display("Run complete: PASS");
		else
			$display("Run complete: FAIL");
		$finish;
	endtask
	// one edge, then settle; a runaway wait ends the run as a failure
	task tick;
		@(posedge sys_clk);
		#1;
		guard++;
		if (guard > 50000) begin
			fail_count++;
			results;
		end
	endtask
	task automatic chk(input string n, input logic [31:0] e, input logic [31:0] s);
		comparisons++;
		if (s !== e) begin
			fail_count++;
			$display("[FAIL] %s expected %h seen %h", n, e, s);
		end
	endtask
	// address and data offered together, each released once taken
	task automatic wr(input logic [7:0] a, input logic [31:0] v);
		s_axi_awaddr <= a;
		s_axi_wdata <= v;
		{s_axi_awvalid, s_axi_wvalid, s_axi_bready} <= '1;
		{da, dw} = '0;
		while (!(da && dw)) begin
			{ha, hw} = {s_axi_awready === 1'b1 && !da, s_axi_wready === 1'b1 && !dw};
			tick;
			if (ha) s_axi_awvalid <= '0;
			if (hw) s_axi_wvalid <= '0;
			{da, dw} = {da | ha, dw | hw};
		end
		while (s_axi_bvalid !== 1'b1) tick;
		r = s_axi_bresp;
		tick;
		s_axi_bready <= '0;
	endtask
	task automatic rd(input logic [7:0] a);
		s_axi_araddr <= a;
		{s_axi_arvalid, s_axi_rready} <= '1;
		do begin
			ha = s_axi_arready === 1'b1;
			tick;
		end while (!ha);
		s_axi_arvalid <= '0;
		while (s_axi_rvalid !== 1'b1) tick;
		{d, r} = {s_axi_rdata, s_axi_rresp};
		tick;
		s_axi_rready <= '0;
		tick; // let rready low reach an edge before the next read raises it
	endtask
	initial begin
		void'($urandom(66));
		// corner masks first (none, all), then random ones, each after a fresh reset
		for (int i = 0; i < 5; i++) begin
			rst_n <= '0;
			te <= '0;
			pm <= (i == 0) ? '0 : (i == 1) ? '1 : $urandom;
			repeat (5) tick;
			chk("pullup", 1, memory_data_pullup_en);
			rst_n <= '1;
			w = exp_word(pm);
			while (config_valid !== 1'b1) tick;
			te <= '1; // memory traffic must not reach the captured word
			td <= $urandom;
			chk("vclk_oe", {w[3], w[3]}, {o1, o2});
			chk("arch", {w[17], w[2]}, bus_arch_sel);
			chk("memmode", {w[16], w[14:13]}, memory_mode_sel);
			chk("wake_alt", w[9], wake_port_alt);
			chk("volt", !w[11], voltage_force_stored);
			chk("host", w[15], host_is_32bit);
			chk("lbclk", w[20], local_bus_clk_1x);
			chk("panel", w[19:18], panel_select);
			chk("lbi", w[31:22], {p0, p1});
			rd(8'h08);
			chk("word", w, d);
			rd(8'h00);
			chk("romreg", {!w[1], !w[0]}, d);
			rd(8'h04);
			chk("gstat", {~w[6:4], 4'h0}, d);
			wr(8'h08, ~w);
			chk("bresp", scc_pkg::RESP_OKAY, r);
			rd(8'h08);
			w = w ^ scc_pkg::SOFT_MASK;
			chk("soft", w, d);
			chk("romout", !w[0], rom_mapped_out);
			chk("host_soft", w[15], host_is_32bit);
			chk("lbclk_soft", w[20], local_bus_clk_1x);
			rd(8'h1C); // unmapped offset
			chk("resp", scc_pkg::RESP_SLVERR, r);
			if (!w[9]) begin
				io_addr <= scc_pkg::PORT_WAKE;
				io_wdata <= 8'h01;
				io_wr_stb <= '1;
				tick;
				io_wr_stb <= '0;
				tick;
				chk("awake", 1, subsystem_awake);
			end
		end
		results;
	end
endmodule // tb_top
`default_nettype wire
